// File: cll_pkg.sv
// Package with register indices, field positions and encodings.
`default_nettype none
package cll_pkg;
  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int NTBL = 2;
  localparam int NSRC = 8;
  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [5:0] IDX_GLOBAL  = 6'h00;
  localparam logic [5:0] IDX_SEQ     = 6'h01;
  localparam logic [5:0] IDX_CTRL_A0 = 6'h05;
  localparam logic [5:0] IDX_CTRL_B0 = 6'h06;
  localparam logic [5:0] IDX_CTRL_C0 = 6'h07;
  localparam logic [5:0] IDX_TRUTH0  = 6'h08;
  localparam logic [5:0] IDX_STRIDE  = 6'h04;
  localparam logic [5:0] IDX_STATUS  = 6'h10;
  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int G_EN     = 0;
  localparam int A_EN     = 0;
  localparam int A_OUTEN  = 3;
  localparam int A_FILT   = 4;
  localparam int A_TABLE_CLOCK_SOURCE_SELECT = 6;
  localparam int A_EDGE   = 7;
  localparam int B_INPUT_SOURCE_SELECT_1 = 4;
  localparam int B_INPUT_SOURCE_SELECT_0 = 0;
  localparam int C_INPUT_SOURCE_SELECT_2 = 0;
  localparam int S_ACT    = 3;
  localparam int S_SEQ    = 2;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam int HTRANS_ACT = 1;
  localparam logic HRESP_OKAY = 1'h0;
  // ************************************************************
  // Encodings
  // ************************************************************
  typedef enum logic [1:0] {
    FILT_OFF   = 2'h0,
    FILT_SYNC  = 2'h1,
    FILT_SPIKE = 2'h2
  } cll_filt_type;
  typedef enum logic [3:0] {
    SEQ_OFF   = 4'h0,
    SEQ_DFF   = 4'h1,
    SEQ_JK    = 4'h2,
    SEQ_LATCH = 4'h3,
    SEQ_RS    = 4'h4
  } cll_seq_type;
  typedef enum logic [3:0] {
    IN_MASK     = 4'h0,
    IN_FEEDBACK = 4'h1,
    IN_LINK     = 4'h2,
    IN_EVENT_INPUT_LINE_0   = 4'h3,
    IN_EVENT_INPUT_LINE_1   = 4'h4,
    IN_PIN      = 4'h5
  } cll_insel_type;
endpackage
`default_nettype wire

// File: cll_top.sv
// Configurable look-up table logic pair with AHB-Lite registers.
`default_nettype none
// Operation
// - Pair control fields other than the enable bits, and sequencer select, only land while even table is off.
// - Even table's protected fields land with an enabling write, never with a disabling one.
// - Global enable bit switches the whole block on or off.
// - Each table has its own enable bit.
// - Output is truth bit indexed by input vector, input 2 most significant.
// - Masked or unused inputs index as low.
// - Feedback input of both tables takes the pair sequencer output.
// - Link input of table n takes table n+1, the last takes table 0.
// - Two event lines are selectable inputs; software routes them first.
// - Synchronizer option delays output by two selected clock edges.
// - Spike filter passes levels stable over three edges, four edges delay.
// - Filter state clears one cycle after the table is disabled.
// - Edge detector pulses on each rising edge of the filtered output.
// - Edge detector state clears one cycle after the table is disabled.
// - One sequencer per pair: D flip-flop, JK, D latch or set-clear latch.
// - Sequencer inputs come from table, filter or edge stage as enabled.
// - Sequencer runs on the even table's selected clock.
// - Flip-flops update on rising edge; even disable masks sequencer output at once.
// - D flip-flop: reset clears, gate high loads data, gate low holds.
// - JK: hold, clear, set, toggle on the clock edge; reset clears.
// - D latch follows data while gate high, holds while gate low.
// - No halt on debug; the block keeps running.
// - Clock source select makes input 2 the clock and indexes it low.
// - Filter select: 0 off, 1 synchronizer, 2 spike filter, 3 reserved.
// - Sequencer select: 0 off, 1 DFF, 2 JK, 3 latch, 4 set-clear.
// - Set-clear latch: hold, clear, set; both high is forbidden.
module cll_top (
  // Clock, reset and freeze
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  // Pins and event lines
  input  wire logic [5:0]  table_input_pin,
  input  wire logic [1:0]  event_input_line,
  output var  logic [1:0]  table_output_signal,
  output var  logic [1:0]  table_output_enable
);
  localparam int NT = cll_pkg::NTBL;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic                 glob_en;
    logic [3:0]           sequencer_function_select;
    logic [1:0]           en;
    logic [1:0]           en_d;
    logic [1:0]           edge_en;
    logic [1:0]           table_clock_source_select;
    logic [1:0]           outen;
    logic [1:0][1:0]      filt;
    logic [1:0][2:0][3:0] insel;
    logic [1:0][7:0]      truth;
    logic [7:0]           syn1;
    logic [7:0]           syn2;
    logic [1:0]           lut_q;
    logic [1:0]           in2_prev;
    logic [1:0]           s0;
    logic [1:0]           s1;
    logic [1:0]           s2;
    logic [1:0]           fo;
    logic [1:0]           eprev;
    logic [1:0]           pulse;
    logic                 seq_q;
    logic [1:0]           pin_out;
    logic [1:0]           pin_oe;
    logic                 ap_valid;
    logic                 ap_write;
    logic [5:0]           ap_idx;
    logic [31:0]          rdata;
    logic                 ready;
  } cll_state_type;

  cll_state_type r;
  cll_state_type n;

  initial
  begin
    if (NT != 2)
      $error("cll_top serves exactly one table pair");
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [5:0] tidx(input logic [5:0] base,
                                      input logic t);
    return base + (t ? cll_pkg::IDX_STRIDE : 6'h00);
  endfunction

  function automatic logic src_pick(input logic [3:0] sel,
                                    input logic fb,
                                    input logic lk,
                                    input logic e0,
                                    input logic e1,
                                    input logic pin);
    logic v;
    v = 1'h0;
    case (sel)
      cll_pkg::IN_FEEDBACK: v = fb;
      cll_pkg::IN_LINK:     v = lk;
      cll_pkg::IN_EVENT_INPUT_LINE_0:   v = e0;
      cll_pkg::IN_EVENT_INPUT_LINE_1:   v = e1;
      cll_pkg::IN_PIN:      v = pin;
      default:              v = 1'h0;
    endcase
    return v;
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  logic [1:0]      act;
  logic [1:0][2:0] vin;
  logic [1:0][2:0] vec;
  logic [1:0]      raw;
  logic [1:0]      tick;
  logic [1:0]      fout;
  logic [1:0]      stage;
  logic [1:0]      outv;
  logic            seq_out;
  logic [7:0]      wd;
  logic            prot;
  logic            take;

  always_comb
  begin
    n = r;
    act = '0;
    vin = '0;
    vec = '0;
    raw = '0;
    tick = '0;
    fout = '0;
    stage = '0;
    outv = '0;
    wd = hwdata[7:0];
    prot = r.en[0];
    take = hsel & hready & htrans[cll_pkg::HTRANS_ACT];
    // ************************************************************
    // Input synchronisers
    // ************************************************************
    // Pins and event lines are asynchronous to hclk.
    n.syn1 = {event_input_line, table_input_pin};
    n.syn2 = r.syn1;
    // Sequencer is masked at once when the even table drops out.
    seq_out = act[0];
    for (int t = 0; t < NT; t++)
    begin
      act[t] = r.glob_en & r.en[t];
    end
    seq_out = act[0] & r.seq_q;
    // ************************************************************
    // Table datapath
    // ************************************************************
    // The link input reads the registered output of the next table,
    // which keeps the ring of tables free of a combinational loop.
    for (int t = 0; t < NT; t++)
    begin
      for (int i = 0; i < 3; i++)
      begin
        vin[t][i] = src_pick(r.insel[t][i], seq_out,
                             r.lut_q[(t + 1) % NT],
                             r.syn2[6], r.syn2[7],
                             r.syn2[t * 3 + i]);
      end
      vec[t] = vin[t];
      if (r.table_clock_source_select[t])
        vec[t][2] = 1'h0;
      raw[t] = act[t] & r.truth[t][vec[t]];
      n.lut_q[t] = raw[t];
      // A rising edge of input 2 stands in for the table clock.
      tick[t] = ~r.table_clock_source_select[t] | (vin[t][2] & ~r.in2_prev[t]);
      n.in2_prev[t] = vin[t][2];
      n.en_d[t] = act[t];
      if (!r.en_d[t])
      begin
        n.s0[t] = 1'h0;
        n.s1[t] = 1'h0;
        n.s2[t] = 1'h0;
        n.fo[t] = 1'h0;
        n.eprev[t] = 1'h0;
        n.pulse[t] = 1'h0;
      end
      else if (tick[t])
      begin
        n.s0[t] = raw[t];
        n.s1[t] = r.s0[t];
        n.s2[t] = r.s1[t];
        if (r.s0[t] == r.s1[t] && r.s1[t] == r.s2[t])
          n.fo[t] = r.s2[t];
      end
      case (r.filt[t])
        cll_pkg::FILT_SYNC:  fout[t] = r.s1[t];
        cll_pkg::FILT_SPIKE: fout[t] = r.fo[t];
        // The reserved code behaves as no filter at all.
        default:             fout[t] = raw[t];
      endcase
      if (r.en_d[t] && tick[t])
      begin
        n.eprev[t] = fout[t];
        // Pulse holds until the next selected clock edge.
        n.pulse[t] = r.edge_en[t] & fout[t] & ~r.eprev[t];
      end
      stage[t] = r.edge_en[t] ? r.pulse[t] : fout[t];
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Sequencer: even stage is D, J or S; odd is G, K or R.
    if (!r.en_d[0])
      n.seq_q = 1'h0;
    else
    begin
      case (r.sequencer_function_select)
        cll_pkg::SEQ_DFF:
        begin
          if (tick[0] && stage[1])
            n.seq_q = stage[0];
        end
        cll_pkg::SEQ_JK:
        begin
          if (tick[0])
          begin
            case ({stage[0], stage[1]})
              2'h1:    n.seq_q = 1'h0;
              2'h2:    n.seq_q = 1'h1;
              2'h3:    n.seq_q = ~r.seq_q;
              default: n.seq_q = r.seq_q;
            endcase
          end
        end
        cll_pkg::SEQ_LATCH:
        begin
          if (stage[1])
            n.seq_q = stage[0];
        end
        cll_pkg::SEQ_RS:
        begin
          // Both high is forbidden; the latch simply holds then.
          if (stage[0] && !stage[1])
            n.seq_q = 1'h1;
          else if (!stage[0] && stage[1])
            n.seq_q = 1'h0;
        end
        default: n.seq_q = 1'h0;
      endcase
    end

    // ************************************************************
    // Pin outputs
    // ************************************************************
    outv[0] = (r.sequencer_function_select != cll_pkg::SEQ_OFF) ? seq_out : stage[0];
    outv[1] = stage[1];
    n.pin_out = act & outv;
    n.pin_oe = act & r.outen;

    // ************************************************************
    // Register writes in the data phase
    // ************************************************************
    if (r.ap_valid && r.ap_write)
    begin
      if (r.ap_idx == cll_pkg::IDX_GLOBAL)
        n.glob_en = wd[cll_pkg::G_EN];
      if (r.ap_idx == cll_pkg::IDX_SEQ && !prot)
        n.sequencer_function_select = wd[3:0];
      for (int t = 0; t < NT; t++)
      begin
        if (r.ap_idx == tidx(cll_pkg::IDX_CTRL_A0, t[0]))
        begin
          n.en[t] = wd[cll_pkg::A_EN];
          // An access that clears the even table's enable finds prot set.
          if (!prot)
          begin
            n.outen[t] = wd[cll_pkg::A_OUTEN];
            n.filt[t] = wd[cll_pkg::A_FILT +: 2];
            n.table_clock_source_select[t] = wd[cll_pkg::A_TABLE_CLOCK_SOURCE_SELECT];
            n.edge_en[t] = wd[cll_pkg::A_EDGE];
          end
        end
        if (r.ap_idx == tidx(cll_pkg::IDX_CTRL_B0, t[0]) && !prot)
        begin
          n.insel[t][0] = wd[cll_pkg::B_INPUT_SOURCE_SELECT_0 +: 4];
          n.insel[t][1] = wd[cll_pkg::B_INPUT_SOURCE_SELECT_1 +: 4];
        end
        if (r.ap_idx == tidx(cll_pkg::IDX_CTRL_C0, t[0]) && !prot)
          n.insel[t][2] = wd[cll_pkg::C_INPUT_SOURCE_SELECT_2 +: 4];
        if (r.ap_idx == tidx(cll_pkg::IDX_TRUTH0, t[0]))
          n.truth[t] = wd;
      end
    end

    // ************************************************************
    // Address phase and read data
    // ************************************************************
    n.ready = 1'h1;
    n.ap_valid = take & (haddr[31:8] == 24'h000000);
    n.ap_write = hwrite;
    n.ap_idx = haddr[7:2];
    n.rdata = cll_pkg::RST_WORD;
    // Read data other than status comes from the updated state, so a read right
    // after a write already sees the written value.
    if (n.ap_valid && !hwrite)
    begin
      if (haddr[7:2] == cll_pkg::IDX_GLOBAL)
        n.rdata[cll_pkg::G_EN] = n.glob_en;
      if (haddr[7:2] == cll_pkg::IDX_SEQ)
        n.rdata[3:0] = n.sequencer_function_select;
      if (haddr[7:2] == cll_pkg::IDX_STATUS)
      begin
        n.rdata[1:0] = r.pin_out;
        n.rdata[cll_pkg::S_SEQ] = seq_out;
        n.rdata[cll_pkg::S_ACT +: 2] = act;
      end
      for (int t = 0; t < NT; t++)
      begin
        if (haddr[7:2] == tidx(cll_pkg::IDX_CTRL_A0, t[0]))
        begin
          n.rdata[cll_pkg::A_EN] = n.en[t];
          n.rdata[cll_pkg::A_OUTEN] = n.outen[t];
          n.rdata[cll_pkg::A_FILT +: 2] = n.filt[t];
          n.rdata[cll_pkg::A_TABLE_CLOCK_SOURCE_SELECT] = n.table_clock_source_select[t];
          n.rdata[cll_pkg::A_EDGE] = n.edge_en[t];
        end
        if (haddr[7:2] == tidx(cll_pkg::IDX_CTRL_B0, t[0]))
          n.rdata[7:0] = {n.insel[t][1], n.insel[t][0]};
        if (haddr[7:2] == tidx(cll_pkg::IDX_CTRL_C0, t[0]))
          n.rdata[3:0] = n.insel[t][2];
        if (haddr[7:2] == tidx(cll_pkg::IDX_TRUTH0, t[0]))
          n.rdata[7:0] = n.truth[t];
      end
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  // No debug halt input exists, so only clk_en low stops the block.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r <= '0;
      r.ready <= 1'h1;
    end
    else if (clk_en)
      r <= n;
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign hreadyout = r.ready;
  assign hresp = r.ap_valid & cll_pkg::HRESP_OKAY;
  assign hrdata = r.rdata;
  assign table_output_signal = r.pin_out;
  assign table_output_enable = r.pin_oe;
endmodule
`default_nettype wire

// File: cll_monitor.sv
// Checker of bus answers and output gating for the look-up table pair.
`default_nettype none
module cll_monitor (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        clk_en,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Table outputs
  input wire logic [1:0]  table_output_signal,
  input wire logic [1:0]  table_output_enable
);
  // ****************************************************************
  // Shadow of the enable bits, taken from completed writes
  // ****************************************************************
  logic       ap_wr_r;
  logic       ap_rd_r;
  logic       gen_r;
  logic [5:0] ap_idx_r;
  logic [1:0] ten_r;
  wire logic  take;
  assign take = hsel & hready & htrans[1] & (haddr[31:8] == 24'h0);
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ap_wr_r  <= 1'b0;
      ap_rd_r  <= 1'b0;
      ap_idx_r <= 6'h00;
      gen_r    <= 1'b0;
      ten_r    <= 2'h0;
    end
    else if (clk_en)
    begin
      ap_wr_r  <= take & hwrite;
      ap_rd_r  <= take & ~hwrite;
      ap_idx_r <= haddr[7:2];
      if (ap_wr_r && ap_idx_r == cll_pkg::IDX_GLOBAL)
        gen_r <= hwdata[0];
      if (ap_wr_r && ap_idx_r == cll_pkg::IDX_CTRL_A0)
        ten_r[0] <= hwdata[0];
      if (ap_wr_r && ap_idx_r == cll_pkg::IDX_CTRL_A0 + cll_pkg::IDX_STRIDE)
        ten_r[1] <= hwdata[0];
    end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ready_high_a: assert property (hreadyout)
    else $error("hreadyout dropped");
  resp_okay_a: assert property (hresp == cll_pkg::HRESP_OKAY)
    else $error("hresp not okay");
  rdata_idle_a: assert property (!ap_rd_r |-> hrdata == 32'h0)
    else $error("hrdata not zero outside read");
  global_read_a: assert property (
    ap_rd_r && ap_idx_r == cll_pkg::IDX_GLOBAL |-> hrdata == {31'h0, gen_r})
    else $error("global enable reads wrong");
  table_read_a: assert property (
    ap_rd_r && ap_idx_r == cll_pkg::IDX_CTRL_A0 |-> hrdata[0] == ten_r[0])
    else $error("table enable reads wrong");
  global_off_a: assert property (
    !gen_r [*3] |-> table_output_enable == 2'h0)
    else $error("output driven while block off");
  global_dark_a: assert property (
    !gen_r [*6] |-> table_output_signal == 2'h0)
    else $error("output high while block off");
  table0_off_a: assert property (
    !ten_r[0] [*3] |-> !table_output_enable[0])
    else $error("table 0 driven while off");
  table1_off_a: assert property (
    $fell(ten_r[1]) |-> ##2 (!table_output_enable[1]) [*2])
    else $error("table 1 driven after disable");
endmodule
bind cll_top cll_monitor mon (.hclk(hclk), .hresetn(hresetn),
  .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .table_output_signal(table_output_signal),
  .table_output_enable(table_output_enable));
`default_nettype wire

// File: cll_pin_model.sv
// Behavioural model of the pins and event lines feeding the tables.
`default_nettype none
module cll_pin_model (
  // Clock and control
  input  wire logic       hclk,
  input  wire logic       slow,
  input  wire logic [7:0] want,
  // Lines into the block
  output var  logic [5:0] pin,
  output var  logic [1:0] evt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] hold_r;
  initial
  begin
    hold_r = 8'h00;
    {evt, pin} = 8'h00;
  end
  // A slow source shows a change one cycle late, as a far pin may.
  always @(posedge hclk)
  begin
    hold_r <= want;
    {evt, pin} <= slow ? hold_r : want;
  end
endmodule
`default_nettype wire

// File: tb_configurable_lut_logic.sv
// Self-checking bench for the look-up table pair.
`default_nettype none
module tb_configurable_lut_logic;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0, ev, oe, tout;
  logic [5:0]  pin;
  logic [7:0]  want = 8'h00, t;
  logic        slow = 1'b0, hresp, q, a, b;
  int          cnt;
  wire logic   hready;
  int          miscompares = 0, num_checks = 0;
  always #10 hclk = ~hclk;
  cll_top DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .table_input_pin(pin), .event_input_line(ev),
    .table_output_signal(tout), .table_output_enable(oe));
  cll_pin_model pm (.hclk(hclk), .slow(slow), .want(want), .pin(pin),
    .evt(ev));
  // ****************************************************************
  // Bus tasks, expectations and reporting
  // ****************************************************************
  task automatic xfer(input logic w, input logic [31:0] ad,
                      input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= ad;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    xfer(1'b1, {24'h0, i, 2'h0}, d);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [5:0] i, input logic [31:0] exp);
    xfer(1'b0, {24'h0, i, 2'h0}, 8'h00);
    chk(rd, exp);
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Set-clear kinds (codes 2 and 4) never see both inputs high here.
  function automatic logic seq_next(input int c, input logic q0,
                                    input logic x, input logic y);
    if (c == 1 || c == 3)
      return y ? x : q0;
    return (x & ~y) | (q0 & ~y);
  endfunction
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    #600000;
    miscompares++;
    end_of_test;
  end
  initial
  begin
    void'($urandom(67));
    pause(2);
    hresetn <= 1'b1;
    pause(1);
    chk_rd(cll_pkg::IDX_GLOBAL, 32'h0);
    chk_rd(cll_pkg::IDX_CTRL_A0, 32'h0);
    xfer(1'b0, 32'h0000_0100, 8'h00);
    chk(rd, 32'h0);
    $display("reset test done");
    wr(cll_pkg::IDX_CTRL_A0, 8'h11);
    chk_rd(cll_pkg::IDX_CTRL_A0, 32'h11);
    wr(cll_pkg::IDX_CTRL_B0, 8'h55);
    wr(cll_pkg::IDX_SEQ, 8'h04);
    chk_rd(cll_pkg::IDX_CTRL_B0, 32'h0);
    chk_rd(cll_pkg::IDX_SEQ, 32'h0);
    wr(cll_pkg::IDX_CTRL_A0, 8'h20);
    chk_rd(cll_pkg::IDX_CTRL_A0, 32'h10);
    $display("protection test done");
    for (int m = 0; m < 2; m++)
    begin
      t = 8'($urandom);
      wr(cll_pkg::IDX_CTRL_A0, 8'h00);
      wr(cll_pkg::IDX_CTRL_B0, m ? 8'h43 : 8'h55);
      wr(cll_pkg::IDX_CTRL_C0, m ? 8'h00 : 8'h05);
      wr(cll_pkg::IDX_TRUTH0, t);
      wr(cll_pkg::IDX_CTRL_A0, 8'h09);
      wr(cll_pkg::IDX_GLOBAL, 8'h01);
      for (int k = 0; k < 12; k++)
      begin
        want <= 8'($urandom);
        slow <= 1'($urandom);
        pause(8);
        chk(tout[0], t[m ? {1'b0, ev} : pin[2:0]]);
      end
      chk(oe[0], 1'b1);
    end
    $display("truth table test done");
    wr(cll_pkg::IDX_CTRL_A0, 8'h00);
    wr(cll_pkg::IDX_CTRL_B0, 8'h05);
    wr(cll_pkg::IDX_CTRL_C0, 8'h00);
    wr(cll_pkg::IDX_TRUTH0, 8'hAA);
    wr(cll_pkg::IDX_CTRL_B0 + cll_pkg::IDX_STRIDE, 8'h05);
    wr(cll_pkg::IDX_CTRL_C0 + cll_pkg::IDX_STRIDE, 8'h00);
    wr(cll_pkg::IDX_TRUTH0 + cll_pkg::IDX_STRIDE, 8'hAA);
    wr(cll_pkg::IDX_CTRL_A0 + cll_pkg::IDX_STRIDE, 8'h09);
    for (int c = 1; c < 5; c++)
    begin
      wr(cll_pkg::IDX_CTRL_A0, 8'h00);
      wr(cll_pkg::IDX_SEQ, 8'(c));
      want <= 8'h00;
      pause(4);
      wr(cll_pkg::IDX_CTRL_A0, 8'h09);
      q = 1'b0;
      for (int k = 0; k < 10; k++)
      begin
        a = 1'($urandom);
        b = 1'($urandom) & (c[0] | ~a);
        want <= {4'h0, b, 2'h0, a};
        pause(8);
        q = seq_next(c, q, a, b);
        chk(tout[0], q);
      end
    end
    wr(cll_pkg::IDX_CTRL_A0, 8'h00);
    pause(2);
    chk(tout[0], 1'b0);
    $display("sequencer test done");
    wr(cll_pkg::IDX_SEQ, 8'h00);
    slow <= 1'b0;
    for (int f = 1; f < 3; f++)
    begin
      want <= 8'h00;
      wr(cll_pkg::IDX_CTRL_A0, 8'h00);
      wr(cll_pkg::IDX_CTRL_A0, (f == 1) ? 8'h99 : 8'h29);
      pause(8);
      want <= 8'h01;
      pause(1);
      want <= 8'h00;
      cnt = 0;
      repeat (12)
      begin
        @(posedge hclk);
        cnt += int'(tout[0]);
      end
      chk(cnt, (f == 1) ? 1 : 0);
      want <= 8'h01;
      pause(12);
      chk(tout[0], (f == 2) ? 1'b1 : 1'b0);
    end
    $display("filter and edge test done");
    wr(cll_pkg::IDX_CTRL_A0, 8'h00);
    wr(cll_pkg::IDX_CTRL_B0, 8'h02);
    wr(cll_pkg::IDX_CTRL_A0, 8'h09);
    for (int k = 0; k < 6; k++)
    begin
      want <= 8'($urandom);
      pause(8);
      chk(tout[1], pin[3]);
      chk(tout[0], pin[3]);
    end
    $display("link test done");
    wr(cll_pkg::IDX_CTRL_A0, 8'h09);
    wr(cll_pkg::IDX_CTRL_A0 + cll_pkg::IDX_STRIDE, 8'h00);
    wr(cll_pkg::IDX_GLOBAL, 8'h00);
    pause(6);
    chk(oe, 2'h0);
    chk(tout, 2'h0);
    chk_rd(cll_pkg::IDX_STATUS, 32'h0);
    $display("global enable test done");
    end_of_test;
  end
endmodule
`default_nettype wire
